// File: shared/tmr_pkg.sv
// constants, field layout and types for the 16-bit timer core
//
// Contract
// - with no clock source selected the counter neither counts nor clears.
// - timer tick comes from internal prescaler or external count pin edge.
// - each compare value is compared with count, driving its wave pin.
// - compare match on A or B sets that channel's flag.
// - an edge from capture pin or comparator copies count into capture value, except in modes where capture sets top.
// - a noise canceler filters the capture input against short spikes.
// - top is 0x00ff, 0x01ff, 0x03ff, 0xffff, compare A or capture, by mode.
// - compare A as top in pwm gives no pwm output; stays double buffered.
// - count 0x0000 is bottom and 0xffff is max.
// - both compare values are double buffered, updated at the mode's point.
// - one shared 8-bit high-byte holding register for all 16-bit values.
// - low-byte write loads held high byte and written low byte together.
// - count or capture low-byte read copies that register's high byte into holding register.
// - compare high-byte reads bypass the holding register and leave it alone.
// - the timer stays disabled while its power-off bit is one.
// - four flags are visible and individually masked onto their requests.
// - both control registers are plain 8-bit read/write registers.
// - a cpu write to count beats any clear or count that cycle.
// - clock select zero stops the timer; count stays readable and writable.
package tmr_pkg;
  // register byte addresses
  localparam logic [7:0] OFS_CTRL_A  = 8'h00;
  localparam logic [7:0] OFS_CTRL_B  = 8'h04;
  localparam logic [7:0] OFS_CNT_L   = 8'h08;
  localparam logic [7:0] OFS_CNT_H   = 8'h0c;
  localparam logic [7:0] OFS_CMPA_L  = 8'h10;
  localparam logic [7:0] OFS_CMPA_H  = 8'h14;
  localparam logic [7:0] OFS_CMPB_L  = 8'h18;
  localparam logic [7:0] OFS_CMPB_H  = 8'h1c;
  localparam logic [7:0] OFS_CAP_L   = 8'h20;
  localparam logic [7:0] OFS_CAP_H   = 8'h24;
  localparam logic [7:0] OFS_FLAG    = 8'h28;
  localparam logic [7:0] OFS_MASK    = 8'h2c;
  localparam logic [7:0] OFS_POWER   = 8'h30;
  // control field positions
  localparam int CA_WGM_LSB  = 0;
  localparam int CA_COMB_LSB = 4;
  localparam int CA_COMA_LSB = 6;
  localparam int CB_CS_LSB   = 0;
  localparam int CB_WGM_LSB  = 3;
  localparam int CB_SRC_BIT  = 5;
  localparam int CB_EDGE_BIT = 6;
  localparam int CB_NC_BIT   = 7;
  // flag and mask bit positions
  localparam int FLG_OVF  = 0;
  localparam int FLG_CMPA = 1;
  localparam int FLG_CMPB = 2;
  localparam int FLG_CAP  = 5;
  localparam int PWR_BIT  = 0;
  // reset values
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  // count landmarks
  localparam logic [15:0] TOP_8  = 16'h00ff;
  localparam logic [15:0] TOP_9  = 16'h01ff;
  localparam logic [15:0] TOP_10 = 16'h03ff;
  localparam logic [15:0] BOTTOM = 16'h0000;
  localparam logic [15:0] MAX    = 16'hffff;
  // noise canceler sample count, prescaler width
  localparam int NC_SAMPLES = 4;
  localparam int PRE_W      = 10;
  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // clock select codes
  typedef enum logic [2:0] {
    CS_NONE     = 3'b000,
    CS_DIV1     = 3'b001,
    CS_DIV8     = 3'b010,
    CS_DIV64    = 3'b011,
    CS_DIV256   = 3'b100,
    CS_DIV1024  = 3'b101,
    CS_EXT_FALL = 3'b110,
    CS_EXT_RISE = 3'b111
  } tmr_cs_t;
endpackage

// File: design/tmr_core.sv
// 16-bit timer/counter core with byte-wide registers behind an axi4-lite slave
//
// Added by the designer: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ns
module tmr_core
  import tmr_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // clock, reset, enable
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              ce,
  // axi4-lite write
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  // axi4-lite read
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // pins
  input  wire logic              ext_count_pin,
  input  wire logic              capture_pin,
  input  wire logic              comparator_in,
  output logic                   wave_out_a,
  output logic                   wave_out_b,
  // interrupt requests
  output logic                   irq_overflow,
  output logic                   irq_compare_a,
  output logic                   irq_compare_b,
  output logic                   irq_capture
);

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0]  control_a_r, control_b_r, irq_flag_reg_r, irq_mask_reg_r, hold_hi_r;
  logic [15:0] count_value_r, count_value_nxt;
  logic [15:0] cmp_a_buf_r, cmp_b_buf_r, cmp_a_act_r, cmp_b_act_r, capture_value_r;
  logic        timer_power_off_r, dir_down_r, dir_down_nxt;
  logic        wave_a_r, wave_b_r;
  // bus state
  logic              aw_hold_r, w_hold_r, bvalid_r, rvalid_r;
  logic [ADDR_W-1:0] aw_addr_r;
  logic [7:0]        w_byte_r;
  logic              w_lane0_r;
  logic [1:0]        bresp_r, rresp_r;
  logic [31:0]       rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // mode decoding
  function automatic logic [15:0] top_of(input logic [3:0] m, input logic [15:0] oa,
                                         input logic [15:0] ic);
    case (m)
      4'd1, 4'd5: top_of = TOP_8;
      4'd2, 4'd6: top_of = TOP_9;
      4'd3, 4'd7: top_of = TOP_10;
      4'd4, 4'd9, 4'd11, 4'd15: top_of = oa;
      4'd8, 4'd10, 4'd12, 4'd14: top_of = ic;
      default: top_of = MAX;
    endcase
  endfunction

  function automatic logic dual_of(input logic [3:0] m);
    dual_of = (m inside {4'd1, 4'd2, 4'd3, 4'd8, 4'd9, 4'd10, 4'd11});
  endfunction

  function automatic logic fast_of(input logic [3:0] m);
    fast_of = (m inside {4'd5, 4'd6, 4'd7, 4'd14, 4'd15});
  endfunction

  // next wave level for one channel
  function automatic logic wave_of(input logic [1:0] com, input logic dual, input logic fast,
                                   input logic match, input logic wrap, input logic down,
                                   input logic cur);
    wave_of = cur;
    if (com != 2'b00) begin
      if (!dual && !fast) begin
        if (match) wave_of = (com == 2'b01) ? !cur : com[0];
      end else if (com[1]) begin
        if (fast && wrap) wave_of = !com[0];
        if (match) wave_of = (dual && down) ? !com[0] : com[0];
      end
    end
  endfunction

  logic [3:0]  wgm;
  logic        dual, fast, pwm, ocra_top, icr_top;
  logic [15:0] top_val;
  tmr_cs_t     cs;
  assign wgm      = {control_b_r[CB_WGM_LSB+1 -: 2], control_a_r[CA_WGM_LSB+1 -: 2]};
  assign dual     = dual_of(wgm);
  assign fast     = fast_of(wgm);
  assign pwm      = dual | fast;
  assign ocra_top = (wgm == 4'd9) || (wgm == 4'd11) || (wgm == 4'd15);
  assign icr_top  = (wgm == 4'd8) || (wgm == 4'd10) || (wgm == 4'd12) || (wgm == 4'd14);
  assign top_val  = top_of(wgm, cmp_a_act_r, capture_value_r);
  assign cs       = tmr_cs_t'(control_b_r[CB_CS_LSB+2 -: 3]);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and prescaler
  logic [PRE_W-1:0] pre_r;
  logic ext_s1, ext_s2, ext_s3, cap_s1, cap_s2, acmp_s1, acmp_s2;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {ext_s1, ext_s2, ext_s3} <= 3'h0;
      {cap_s1, cap_s2, acmp_s1, acmp_s2} <= 4'h0;
    end else if (ce) begin
      ext_s1  <= ext_count_pin;
      ext_s2  <= ext_s1;
      ext_s3  <= ext_s2;
      cap_s1  <= capture_pin;
      cap_s2  <= cap_s1;
      acmp_s1 <= comparator_in;
      acmp_s2 <= acmp_s1;
    end
  end

  // free prescaler, held while powered off
  always_ff @(posedge aclk) begin
    if (!aresetn) pre_r <= '0;
    else if (ce && !timer_power_off_r) pre_r <= pre_r + 1'b1;
  end

  // timer tick selection
  logic timer_tick;
  always_comb begin
    case (cs)
      CS_DIV1:     timer_tick = 1'b1;
      CS_DIV8:     timer_tick = &pre_r[2:0];
      CS_DIV64:    timer_tick = &pre_r[5:0];
      CS_DIV256:   timer_tick = &pre_r[7:0];
      CS_DIV1024:  timer_tick = &pre_r[9:0];
      CS_EXT_FALL: timer_tick = !ext_s2 && ext_s3;
      CS_EXT_RISE: timer_tick = ext_s2 && !ext_s3;
      default:     timer_tick = 1'b0;
    endcase
    timer_tick = timer_tick && ce && !timer_power_off_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus handshake and decode
  logic wr_go, rd_go, wr_lo;
  assign awready = ce && !aw_hold_r;
  assign wready  = ce && !w_hold_r;
  assign arready = ce && !rvalid_r;
  assign bvalid  = bvalid_r;
  assign bresp   = bresp_r;
  assign rvalid  = rvalid_r;
  assign rresp   = rresp_r;
  assign rdata   = rdata_r;
  assign wr_go   = ce && aw_hold_r && w_hold_r && !bvalid_r;
  assign rd_go   = ce && arvalid && !rvalid_r;
  assign wr_lo   = wr_go && w_lane0_r;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    hit = (a == ADDR_W'(ofs));
  endfunction

  logic wr_cnt, wr_cmpa, wr_cmpb, wr_cap, wr_hi, wr_flag;
  assign wr_cnt  = wr_lo && hit(aw_addr_r, OFS_CNT_L);
  assign wr_cmpa = wr_lo && hit(aw_addr_r, OFS_CMPA_L);
  assign wr_cmpb = wr_lo && hit(aw_addr_r, OFS_CMPB_L);
  assign wr_cap  = wr_lo && hit(aw_addr_r, OFS_CAP_L);
  assign wr_flag = wr_lo && hit(aw_addr_r, OFS_FLAG);
  assign wr_hi   = wr_lo && (hit(aw_addr_r, OFS_CNT_H) || hit(aw_addr_r, OFS_CMPA_H)
                   || hit(aw_addr_r, OFS_CMPB_H) || hit(aw_addr_r, OFS_CAP_H));

  // write address and data capture, in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {aw_hold_r, w_hold_r, w_lane0_r} <= 3'h0;
      aw_addr_r <= '0;
      w_byte_r  <= RST_BYTE;
    end else if (ce) begin
      if (awvalid && !aw_hold_r) begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= awaddr;
      end else if (wr_go) aw_hold_r <= 1'b0;
      if (wvalid && !w_hold_r) begin
        w_hold_r  <= 1'b1;
        w_byte_r  <= wdata[7:0];
        w_lane0_r <= wstrb[0];
      end else if (wr_go) w_hold_r <= 1'b0;
    end
  end

  // write response, error for unmapped address
  logic wr_mapped;
  assign wr_mapped = (aw_addr_r[1:0] == 2'b00) && (aw_addr_r <= ADDR_W'(OFS_POWER));
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end else if (ce) begin
      if (wr_go) begin
        bvalid_r <= 1'b1;
        bresp_r  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) bvalid_r <= 1'b0;
    end
  end

  // read data mux, compare high bytes come straight from the buffer
  logic [7:0] rd_byte;
  logic       rd_ok;
  always_comb begin
    rd_ok = 1'b1;
    if (hit(araddr, OFS_CTRL_A))      rd_byte = control_a_r;
    else if (hit(araddr, OFS_CTRL_B)) rd_byte = control_b_r;
    else if (hit(araddr, OFS_CNT_L))  rd_byte = count_value_r[7:0];
    else if (hit(araddr, OFS_CNT_H))  rd_byte = hold_hi_r;
    else if (hit(araddr, OFS_CMPA_L)) rd_byte = cmp_a_buf_r[7:0];
    else if (hit(araddr, OFS_CMPA_H)) rd_byte = cmp_a_buf_r[15:8];
    else if (hit(araddr, OFS_CMPB_L)) rd_byte = cmp_b_buf_r[7:0];
    else if (hit(araddr, OFS_CMPB_H)) rd_byte = cmp_b_buf_r[15:8];
    else if (hit(araddr, OFS_CAP_L))  rd_byte = capture_value_r[7:0];
    else if (hit(araddr, OFS_CAP_H))  rd_byte = hold_hi_r;
    else if (hit(araddr, OFS_FLAG))   rd_byte = irq_flag_reg_r;
    else if (hit(araddr, OFS_MASK))   rd_byte = irq_mask_reg_r;
    else if (hit(araddr, OFS_POWER))  rd_byte = {7'h00, timer_power_off_r};
    else begin
      rd_byte = RST_BYTE;
      rd_ok   = 1'b0;
    end
  end

  // read response register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= RESP_OKAY;
    end else if (ce) begin
      if (rd_go) begin
        rvalid_r <= 1'b1;
        rdata_r  <= {24'h00_0000, rd_byte};
        rresp_r  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (rready) rvalid_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shared high-byte holding register
  always_ff @(posedge aclk) begin
    if (!aresetn) hold_hi_r <= RST_BYTE;
    else if (ce) begin
      if (wr_hi) hold_hi_r <= w_byte_r;
      else if (rd_go && hit(araddr, OFS_CNT_L)) hold_hi_r <= count_value_r[15:8];
      else if (rd_go && hit(araddr, OFS_CAP_L)) hold_hi_r <= capture_value_r[15:8];
    end
  end

  // plain byte registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {control_a_r, control_b_r, irq_mask_reg_r} <= {3{RST_BYTE}};
      timer_power_off_r <= 1'b0;
    end else if (ce && wr_lo) begin
      if (hit(aw_addr_r, OFS_CTRL_A)) control_a_r <= w_byte_r;
      if (hit(aw_addr_r, OFS_CTRL_B)) control_b_r <= w_byte_r;
      if (hit(aw_addr_r, OFS_MASK))
        irq_mask_reg_r <= w_byte_r & 8'h27;
      if (hit(aw_addr_r, OFS_POWER)) timer_power_off_r <= w_byte_r[PWR_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // counter sequence
  logic at_top, wrap, ovf_set;
  assign at_top = (count_value_r == top_val);
  assign wrap   = timer_tick && !dual && at_top;
  always_comb begin
    count_value_nxt = count_value_r;
    dir_down_nxt    = dir_down_r;
    ovf_set         = 1'b0;
    if (timer_tick) begin
      if (dual) begin
        if (!dir_down_r && count_value_r >= top_val) begin
          dir_down_nxt    = 1'b1;
          count_value_nxt = count_value_r - 16'h0001;
        end else if (dir_down_r && count_value_r == BOTTOM) begin
          dir_down_nxt    = 1'b0;
          count_value_nxt = count_value_r + 16'h0001;
        end else begin
          count_value_nxt = dir_down_r ? count_value_r - 16'h0001 : count_value_r + 16'h0001;
          ovf_set = dir_down_r && (count_value_r == 16'h0001);
        end
      end else begin
        count_value_nxt = at_top ? BOTTOM : count_value_r + 16'h0001;
        ovf_set = fast ? at_top : (count_value_r == MAX);
      end
    end
    if (wr_cnt) count_value_nxt = {hold_hi_r, w_byte_r};
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_value_r <= RST_WORD;
      dir_down_r    <= 1'b0;
    end else if (ce) begin
      count_value_r <= count_value_nxt;
      dir_down_r    <= dir_down_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // compare buffers and their update point
  logic upd_pt, match_a, match_b;
  assign upd_pt  = !pwm || (fast ? wrap : (timer_tick && !dir_down_r && count_value_r >= top_val));
  assign match_a = timer_tick && (count_value_r == cmp_a_act_r);
  assign match_b = timer_tick && (count_value_r == cmp_b_act_r);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {cmp_a_buf_r, cmp_b_buf_r, cmp_a_act_r, cmp_b_act_r} <= {4{RST_WORD}};
    end else if (ce) begin
      if (wr_cmpa) cmp_a_buf_r <= {hold_hi_r, w_byte_r};
      if (wr_cmpb) cmp_b_buf_r <= {hold_hi_r, w_byte_r};
      if (upd_pt) begin
        cmp_a_act_r <= cmp_a_buf_r;
        cmp_b_act_r <= cmp_b_buf_r;
      end
    end
  end

  // wave outputs, channel a silent when it sets top in pwm
  always_ff @(posedge aclk) begin
    if (!aresetn) {wave_a_r, wave_b_r} <= 2'b00;
    else if (ce) begin
      if (!(pwm && ocra_top))
        wave_a_r <= wave_of(control_a_r[CA_COMA_LSB+1 -: 2], dual, fast, match_a, wrap,
                            dir_down_r, wave_a_r);
      wave_b_r <= wave_of(control_a_r[CA_COMB_LSB+1 -: 2], dual, fast, match_b, wrap,
                          dir_down_r, wave_b_r);
    end
  end
  assign wave_out_a = wave_a_r;
  assign wave_out_b = wave_b_r;

  ////////////////////////////////////////////////////////////////////////////
  // capture input: source select, noise canceler, edge detect
  logic [NC_SAMPLES-1:0] nc_hist_r;
  logic cap_src, filt_r, filt_prev_r, cap_edge;
  assign cap_src  = control_b_r[CB_SRC_BIT] ? acmp_s2 : cap_s2;
  assign cap_edge = (filt_r != filt_prev_r) && (filt_r == control_b_r[CB_EDGE_BIT]);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nc_hist_r <= '0;
      {filt_r, filt_prev_r} <= 2'b00;
    end else if (ce) begin
      nc_hist_r   <= {nc_hist_r[NC_SAMPLES-2:0], cap_src};
      filt_prev_r <= filt_r;
      if (!control_b_r[CB_NC_BIT]) filt_r <= cap_src;
      else if (&nc_hist_r || ~|nc_hist_r) filt_r <= nc_hist_r[0];
    end
  end

  // capture register, hardware capture only when not used as top
  logic cap_evt;
  assign cap_evt = ce && cap_edge && !timer_power_off_r && !icr_top;
  always_ff @(posedge aclk) begin
    if (!aresetn) capture_value_r <= RST_WORD;
    else if (ce) begin
      if (wr_cap) capture_value_r <= {hold_hi_r, w_byte_r};
      else if (cap_evt) capture_value_r <= count_value_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flags: write one to clear, a new event wins over the clear
  logic [7:0] flag_set;
  always_comb begin
    flag_set           = 8'h00;
    flag_set[FLG_OVF]  = ovf_set;
    flag_set[FLG_CMPA] = match_a;
    flag_set[FLG_CMPB] = match_b;
    flag_set[FLG_CAP]  = cap_evt;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) irq_flag_reg_r <= RST_BYTE;
    else if (ce)
      irq_flag_reg_r <= (irq_flag_reg_r & ~(wr_flag ? w_byte_r : 8'h00)) | flag_set;
  end
  assign irq_overflow  = irq_flag_reg_r[FLG_OVF] & irq_mask_reg_r[FLG_OVF];
  assign irq_compare_a = irq_flag_reg_r[FLG_CMPA] & irq_mask_reg_r[FLG_CMPA];
  assign irq_compare_b = irq_flag_reg_r[FLG_CMPB] & irq_mask_reg_r[FLG_CMPB];
  assign irq_capture   = irq_flag_reg_r[FLG_CAP] & irq_mask_reg_r[FLG_CAP];

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_stop_frozen;
    ce && cs == CS_NONE && !wr_cnt |=> $stable(count_value_r);
  endproperty
  a_stop_frozen: assert property (p_stop_frozen) else $error("count moved with no clock");

  property p_low_write_load;
    logic [15:0] v;
    (ce && wr_cnt, v = {hold_hi_r, w_byte_r}) |=> count_value_r == v;
  endproperty
  a_low_write_load: assert property (p_low_write_load) else $error("count load wrong");

  property p_write_priority;
    ce && wr_cnt && timer_tick |=> count_value_r == {$past(hold_hi_r), $past(w_byte_r)};
  endproperty
  a_write_priority: assert property (p_write_priority) else $error("tick beat write");

  property p_match_flag_a;
    ce && timer_tick && count_value_r == cmp_a_act_r |=> irq_flag_reg_r[FLG_CMPA];
  endproperty
  a_match_flag_a: assert property (p_match_flag_a) else $error("compare a flag missed");

  property p_read_low_hold;
    ce && rd_go && hit(araddr, OFS_CNT_L) && !wr_hi |=>
      hold_hi_r == $past(count_value_r[15:8]) ##1 1'b1;
  endproperty
  a_read_low_hold: assert property (p_read_low_hold) else $error("hold not loaded");

  property p_cmp_read_bypass;
    ce && rd_go && hit(araddr, OFS_CMPA_H) && !wr_hi |=> $stable(hold_hi_r)
      ##[0:2] (rvalid_r && rdata_r[7:0] == cmp_a_buf_r[15:8]);
  endproperty
  a_cmp_read_bypass: assert property (p_cmp_read_bypass) else $error("compare read touched hold");

  property p_power_off;
    timer_power_off_r |-> !timer_tick;
  endproperty
  a_power_off: assert property (p_power_off) else $error("tick while powered off");

  property p_fixed_top8;
    ce && wgm == 4'd1 && count_value_r <= TOP_8 && !wr_cnt |=> count_value_r <= TOP_8;
  endproperty
  a_fixed_top8: assert property (p_fixed_top8) else $error("count passed 8-bit top");

  property p_buffered_fast;
    ce && fast && !wrap |=> $stable(cmp_b_act_r);
  endproperty
  a_buffered_fast: assert property (p_buffered_fast) else $error("compare updated early");

  property p_capture_copy;
    cap_evt && !wr_cap |=> capture_value_r == $past(count_value_r) && irq_flag_reg_r[FLG_CAP];
  endproperty
  a_capture_copy: assert property (p_capture_copy) else $error("capture not taken");

  c_write_cycle: cover property (wr_go ##[1:4] (bvalid_r && bready));
  c_read_cycle:  cover property (rd_go ##1 (rvalid_r && rready));
  c_capture:     cover property (cap_evt);
  c_overflow:    cover property (ovf_set ##1 irq_overflow);

endmodule // tmr_core

// File: verification/tmr_cpu_model.sv
// cpu-side axi4-lite master model driving the timer core
`timescale 1ns/1ns
module tmr_cpu_model (
  // clock
  input  wire logic        aclk,
  // write channels
  output logic [7:0]       awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  // read channels
  output logic [7:0]       araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready
);
  // idle bus at time zero
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end
  // one byte write; handshakes sampled at the rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    logic done;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    wstrb <= 4'hf;
    {awvalid, wvalid, bready} <= 3'b111;
    done = 1'b0;
    while (!done) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        done = 1'b1;
        r = bresp;
      end
    end
    bready <= 1'b0;
  endtask
  // one byte read
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic [1:0] r);
    logic done;
    @(posedge aclk);
    araddr <= a;
    {arvalid, rready} <= 2'b11;
    done = 1'b0;
    while (!done) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        done = 1'b1;
        d = rdata[7:0];
        r = rresp;
      end
    end
    rready <= 1'b0;
  endtask
endmodule // tmr_cpu_model

// File: verification/tb_timer16_core_byte_access.sv
// self-checking bench for the 16-bit timer core
`timescale 1ns/1ns
module tb_timer16_core_byte_access;
  import tmr_pkg::*;
  logic        aclk, aresetn, ce, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, ia, ib, io, ic, wa, wb, cap_pin, ext_pin;
  logic [7:0]  awaddr, araddr, d0, d1;
  logic [31:0] wdata, rdata, seed, v;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r;
  int          miscompares, tests_run, n;
  // free-running 50 ns clock
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  tmr_core dut_u (.aclk(aclk), .aresetn(aresetn), .ce(ce), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .ext_count_pin(ext_pin), .capture_pin(cap_pin), .comparator_in(1'b0),
    .wave_out_a(wa), .wave_out_b(wb), .irq_overflow(io), .irq_compare_a(ia),
    .irq_compare_b(ib), .irq_capture(ic));
  tmr_cpu_model cpu_u (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
  // compare and count
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
    end
  endtask
  // write expecting okay, read expecting a byte
  task automatic wc(input logic [7:0] a, input logic [7:0] d);
    cpu_u.wr(a, d, r);
    chk({8'h00, r}, {8'h00, RESP_OKAY});
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    cpu_u.rd(a, d0, r);
    chk({r, d0}, {RESP_OKAY, e});
  endtask
  task automatic end_of_test();
    $display("mismatches %0d checks %0d", miscompares, tests_run);
    if (miscompares == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // watchdog
  initial begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    end_of_test();
  end
  // main sequence
  initial begin
    seed = 32'ha9b5b933;
    {miscompares, tests_run} = '0;
    aresetn = 1'b0;
    ce = 1'b1;
    {cap_pin, ext_pin} = 2'b00;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rc(OFS_CTRL_A, 8'h00);
    rc(OFS_CTRL_B, 8'h00);
    rc(OFS_CNT_L, 8'h00);
    rc(OFS_CAP_L, 8'h00);
    rc(OFS_FLAG, 8'h00);
    rc(OFS_MASK, 8'h00);
    // paired 16-bit access with the timer stopped, corner value first
    for (int i = 0; i < 5; i++) begin
      v = (i == 0) ? 32'h00ff_ff00 : $random(seed);
      wc(OFS_CNT_H, v[15:8]);
      wc(OFS_CNT_L, v[7:0]);
      wc(OFS_CMPA_H, v[31:24]);
      wc(OFS_CMPA_L, v[23:16]);
      rc(OFS_CNT_L, v[7:0]);
      rc(OFS_CMPA_H, v[31:24]);
      rc(OFS_CNT_H, v[15:8]);
      rc(OFS_CMPA_L, v[23:16]);
      wc(OFS_CTRL_A, v[7:0]);
      rc(OFS_CTRL_A, v[7:0]);
      wc(OFS_CTRL_B, {v[15:11], 3'b000});
      rc(OFS_CTRL_B, {v[15:11], 3'b000});
    end
    wc(OFS_CTRL_A, 8'h00);
    wc(OFS_CTRL_B, 8'h00);
    cpu_u.rd(8'h3c, d0, r);
    chk({r, d0}, {RESP_SLVERR, 8'h00});
    // powered off: selecting a clock must not move the count
    wc(OFS_POWER, 8'h01);
    wc(OFS_CNT_H, 8'h00);
    wc(OFS_CNT_L, 8'h00);
    wc(OFS_CTRL_B, {5'b00000, CS_DIV1});
    repeat (20) @(posedge aclk);
    rc(OFS_CNT_L, 8'h00);
    // run from zero, compare A at 0x40 unmasked, compare B at 0 masked
    wc(OFS_CTRL_B, 8'h00);
    wc(OFS_CMPA_H, 8'h00);
    wc(OFS_CMPA_L, 8'h40);
    wc(OFS_CMPB_L, 8'h00);
    wc(OFS_MASK, 8'h02);
    wc(OFS_CTRL_A, 8'h50);
    wc(OFS_POWER, 8'h00);
    wc(OFS_CTRL_B, {5'b00000, CS_DIV1});
    for (n = 0; n < 200 && ia !== 1'b1; n++) @(posedge aclk);
    chk({8'h00, ia, ib}, {8'h00, 2'b10});
    chk({8'h00, wa, wb}, {8'h00, 2'b11});
    wc(OFS_CTRL_B, 8'h00);
    rc(OFS_FLAG, 8'h06);
    wc(OFS_FLAG, 8'h02);
    rc(OFS_FLAG, 8'h04);
    chk({9'h000, ia}, 10'h000);
    cpu_u.rd(OFS_CNT_L, d1, r);
    repeat (20) @(posedge aclk);
    rc(OFS_CNT_L, d1);
    // overflow at max, then filtered capture, then external count edges
    wc(OFS_MASK, 8'h21);
    wc(OFS_CNT_H, 8'hff);
    wc(OFS_CNT_L, 8'hf0);
    wc(OFS_CTRL_B, {5'b00000, CS_DIV1});
    repeat (30) @(posedge aclk);
    chk({9'h000, io}, 10'h001);
    wc(OFS_CTRL_B, 8'hc0);
    wc(OFS_CNT_H, 8'h12);
    wc(OFS_CNT_L, 8'h34);
    cap_pin <= 1'b1;
    @(posedge aclk);
    cap_pin <= 1'b0;
    repeat (12) @(posedge aclk);
    chk({9'h000, ic}, 10'h000);
    cap_pin <= 1'b1;
    repeat (12) @(posedge aclk);
    chk({9'h000, ic}, 10'h001);
    rc(OFS_CAP_L, 8'h34);
    rc(OFS_CAP_H, 8'h12);
    wc(OFS_CTRL_B, {5'b00000, CS_EXT_RISE});
    repeat (3) begin
      ext_pin <= 1'b1;
      repeat (4) @(posedge aclk);
      ext_pin <= 1'b0;
      repeat (4) @(posedge aclk);
    end
    wc(OFS_CTRL_B, 8'h00);
    rc(OFS_CNT_L, 8'h37);
    end_of_test();
  end
endmodule // tb_timer16_core_byte_access
